// ==== core/cbd_pkg.sv ====
// Shared constants and types for the branch, bit and control decode core
package cbd_pkg;

   // ----------------------------------------------------------------
   // Sequencer states (Gray along fetch, operand, read, write path)
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_FETCH = 3'b000,
      ST_OPR1  = 3'b001,
      ST_OPR2  = 3'b011,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b110,
      ST_PUSH  = 3'b111,
      ST_PAD   = 3'b101,
      ST_HALT  = 3'b100
   } cbd_state_t;

   typedef enum logic [2:0]
   {
      ALU_ADC  = 3'd0,
      ALU_ADD  = 3'd1,
      ALU_AND  = 3'd2,
      ALU_SHL  = 3'd3,
      ALU_SHR  = 3'd4
   } cbd_alu_op_t;

   // ----------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------
   localparam logic [3:0] LO_ADC     = 4'h9;
   localparam logic [3:0] LO_ADD     = 4'hB;
   localparam logic [3:0] LO_AND     = 4'h4;
   localparam logic [3:0] LO_SHL     = 4'h8;
   localparam logic [3:0] LO_SHR     = 4'h7;
   localparam logic [3:0] HI_BITBR   = 4'h0;
   localparam logic [3:0] HI_BITMOD  = 4'h1;
   localparam logic [3:0] HI_IMM     = 4'hA;
   localparam logic [3:0] HI_DIR     = 4'hB;
   localparam logic [3:0] HI_EXT     = 4'hC;
   localparam logic [3:0] HI_IX2     = 4'hD;
   localparam logic [3:0] HI_IX1     = 4'hE;
   localparam logic [3:0] HI_IX      = 4'hF;
   localparam logic [3:0] HI_SDIR    = 4'h3;
   localparam logic [3:0] HI_SINA    = 4'h4;
   localparam logic [3:0] HI_SINX    = 4'h5;
   localparam logic [3:0] HI_SIX1    = 4'h6;
   localparam logic [3:0] HI_SIX     = 4'h7;
   localparam logic [7:0] OP_BR_C0   = 8'h24;
   localparam logic [7:0] OP_BR_C1   = 8'h25;
   localparam logic [7:0] OP_BR_EQ   = 8'h27;
   localparam logic [7:0] OP_BR_H0   = 8'h28;
   // Arbitrary defaults for opcodes not fixed here; top parameters
   localparam logic [7:0] OP_JUMP_DFLT = 8'h90;
   localparam logic [7:0] OP_CALL_DFLT = 8'h91;
   localparam logic [7:0] OP_STOP_DFLT = 8'h92;
   localparam logic [7:0] OP_WAIT_DFLT = 8'h93;

   // ----------------------------------------------------------------
   // Cycle counts and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_IMM    = 3'd2;
   localparam logic [2:0] CYC_DIR    = 3'd3;
   localparam logic [2:0] CYC_EXT    = 3'd4;
   localparam logic [2:0] CYC_IX2    = 3'd5;
   localparam logic [2:0] CYC_IX1    = 3'd4;
   localparam logic [2:0] CYC_IX     = 3'd3;
   localparam logic [2:0] CYC_SDIR   = 3'd5;
   localparam logic [2:0] CYC_SINH   = 3'd3;
   localparam logic [2:0] CYC_SIX1   = 3'd6;
   localparam logic [2:0] CYC_SIX    = 3'd5;
   localparam logic [2:0] CYC_REL    = 3'd3;
   localparam logic [2:0] CYC_BITBR  = 3'd5;
   localparam logic [2:0] CYC_BITMOD = 3'd5;
   localparam logic [2:0] CYC_JUMP   = 3'd3;
   localparam logic [2:0] CYC_CALL   = 3'd5;
   localparam logic [2:0] CYC_CTRL   = 3'd2;
   localparam logic [2:0] CYC_UNDEF  = 3'd1;
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [7:0]  SP_RESET  = 8'hFF;

endpackage

// ==== core/cbd_alu_if.sv ====
// Operand and result bundle between the sequencer and its arithmetic unit
`timescale 1ns/1ps
interface cbd_alu_if;
   import cbd_pkg::*;
   cbd_alu_op_t op;
   logic [7:0]  a;
   logic [7:0]  m;
   logic        cin;
   logic [7:0]  res;
   logic        h;
   logic        n;
   logic        z;
   logic        c;
   modport seq (output op, a, m, cin, input res, h, n, z, c);
   modport alu (input op, a, m, cin, output res, h, n, z, c);
endinterface

// ==== core/cbd_alu.sv ====
// Add, logical and, and arithmetic shift unit with condition flags
`timescale 1ns/1ps
module cbd_alu
(
   cbd_alu_if.alu p
);
   import cbd_pkg::*;

   logic [8:0] sum;
   logic [4:0] low_sum;
   logic       use_cin;

   // Carry only enters for the add-with-carry form
   assign use_cin = (p.op == ALU_ADC) ? p.cin : 1'b0;
   assign sum     = {1'b0, p.a} + {1'b0, p.m} + {8'h00, use_cin};
   assign low_sum = {1'b0, p.a[3:0]} + {1'b0, p.m[3:0]} + {4'h0, use_cin};

   // Result select
   assign p.res = (p.op == ALU_AND) ? (p.a & p.m) :
                  (p.op == ALU_SHL) ? {p.m[6:0], 1'b0} :
                  (p.op == ALU_SHR) ? {p.m[7], p.m[7:1]} :
                  sum[7:0];

   // Flags; shifts carry out the bit that falls off
   assign p.h = low_sum[4];
   assign p.n = p.res[7];
   assign p.z = (p.res == 8'h00);
   assign p.c = (p.op == ALU_SHL) ? p.m[7] :
                (p.op == ALU_SHR) ? p.m[0] :
                sum[8];

endmodule

// ==== core/cbd_core.sv ====
// Sequencer for branch, bit, add/and/shift and stop/wait instructions
`timescale 1ns/1ps
module cbd_core
#(
   parameter logic [7:0] JUMP_OPCODE = cbd_pkg::OP_JUMP_DFLT,
   parameter logic [7:0] CALL_OPCODE = cbd_pkg::OP_CALL_DFLT,
   parameter logic [7:0] STOP_OPCODE = cbd_pkg::OP_STOP_DFLT,
   parameter logic [7:0] WAIT_OPCODE = cbd_pkg::OP_WAIT_DFLT
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        core_ce,
   output logic [15:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata,
   output logic [7:0]       mem_wdata,
   output logic             mem_we,
   input  wire logic        irq_pin_n,
   input  wire logic        int_req,
   output logic             osc_run,
   output logic             cpu_clk_run
);
   import cbd_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cbd_state_t  st_r, st_nxt;
   logic [15:0] pc_r, pc_nxt, addr_r, addr_nxt;
   logic [7:0]  op_r, op_nxt, o1_r, o1_nxt, o2_r, o2_nxt;
   logic [7:0]  a_r, a_nxt, x_r, x_nxt, sp_r, sp_nxt, wdata_r, wdata_nxt;
   logic        h_r, h_nxt, i_r, i_nxt, n_r, n_nxt, z_r, z_nxt, c_r, c_nxt;
   logic        we_r, we_nxt, osc_r, osc_nxt, run_r, run_nxt;
   logic [2:0]  cyc_r, cyc_nxt;
   logic        irq_s1_r, irq_s2_r;
   logic        done;

   cbd_alu_if alu_bus ();
   cbd_alu u_alu (.p(alu_bus));

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [7:0]  opc, o1_v, o2_v, off_v, mod_byte;
   logic [3:0]  hi, lo;
   logic [2:0]  bit_n, cyc_need;
   logic [1:0]  n_opr;
   logic [15:0] eff_addr, pc_inc, off_ext, jump_dest;
   logic        is_bitbr, is_bitmod, is_rel, is_shift, is_alu, sh_inh, is_dir_m;
   logic        is_jump, is_call, is_stop, is_wait, need_rd, need_wr, exec_now;
   logic        br_cond, bit_val, bit_hit, wake;

   // Opcode is live on the bus in the fetch cycle, held afterwards
   assign opc       = (st_r == ST_FETCH) ? mem_rdata : op_r;
   assign hi        = opc[7:4];
   assign lo        = opc[3:0];
   assign is_bitbr  = (hi == HI_BITBR);
   assign is_bitmod = (hi == HI_BITMOD);
   assign is_rel    = (opc == OP_BR_C0) || (opc == OP_BR_C1) ||
                      (opc == OP_BR_EQ) || (opc == OP_BR_H0);
   assign is_shift  = (hi >= HI_SDIR) && (hi <= HI_SIX) && ((lo == LO_SHL) || (lo == LO_SHR));
   assign is_alu    = (hi >= HI_IMM) && ((lo == LO_ADC) || (lo == LO_ADD) || (lo == LO_AND));
   assign sh_inh    = is_shift && ((hi == HI_SINA) || (hi == HI_SINX));
   assign is_jump   = (opc == JUMP_OPCODE);
   assign is_call   = (opc == CALL_OPCODE);
   assign is_stop   = (opc == STOP_OPCODE);
   assign is_wait   = (opc == WAIT_OPCODE);

   // Operand bytes, memory read and write-back per class
   assign n_opr = (is_bitbr || is_jump || is_call ||
                   (is_alu && ((hi == HI_EXT) || (hi == HI_IX2)))) ? 2'd2 :
                  (is_bitmod || is_rel || (is_shift && ((hi == HI_SDIR) || (hi == HI_SIX1))) ||
                   (is_alu && ((hi == HI_IMM) || (hi == HI_DIR) || (hi == HI_IX1)))) ? 2'd1 :
                  2'd0;
   assign need_rd = is_bitbr || is_bitmod || (is_shift && !sh_inh) || (is_alu && (hi != HI_IMM));
   assign need_wr = is_bitmod || (is_shift && !sh_inh);

   // Required cycle count per opcode; short sequences are padded
   assign cyc_need = is_rel    ? CYC_REL :
                     is_bitbr  ? CYC_BITBR :
                     is_bitmod ? CYC_BITMOD :
                     is_jump   ? CYC_JUMP :
                     is_call   ? CYC_CALL :
                     (is_stop || is_wait) ? CYC_CTRL :
                     (is_shift && (hi == HI_SDIR)) ? CYC_SDIR :
                     sh_inh                        ? CYC_SINH :
                     (is_shift && (hi == HI_SIX1)) ? CYC_SIX1 :
                     is_shift                      ? CYC_SIX :
                     (is_alu && (hi == HI_IMM)) ? CYC_IMM :
                     (is_alu && (hi == HI_DIR)) ? CYC_DIR :
                     (is_alu && (hi == HI_EXT)) ? CYC_EXT :
                     (is_alu && (hi == HI_IX2)) ? CYC_IX2 :
                     (is_alu && (hi == HI_IX1)) ? CYC_IX1 :
                     is_alu                     ? CYC_IX :
                     CYC_UNDEF;

   // Effective address; operand bytes may still be on the bus
   assign o1_v     = (st_r == ST_OPR1) ? mem_rdata : o1_r;
   assign o2_v     = (st_r == ST_OPR2) ? mem_rdata : o2_r;
   assign is_dir_m = is_bitbr || is_bitmod || (is_shift && (hi == HI_SDIR)) ||
                     (is_alu && (hi == HI_DIR));
   assign eff_addr = is_dir_m ? {8'h00, o1_v} :
                     (hi == HI_IX2) ? ({o1_v, o2_v} + {8'h00, x_r}) :
                     (hi == HI_EXT) ? {o1_v, o2_v} :
                     ((hi == HI_IX1) || (hi == HI_SIX1)) ? ({8'h00, o1_v} + {8'h00, x_r}) :
                     {8'h00, x_r};

   // Branch arithmetic; pc_inc points past a relative branch's offset byte, pc_r past a bit branch's
   assign pc_inc     = pc_r + 16'd1;
   assign off_v      = (st_r == ST_OPR1) ? mem_rdata : o2_r;
   assign off_ext    = {{8{off_v[7]}}, off_v};
   assign jump_dest  = {o1_r, mem_rdata};
   assign br_cond    = ((opc == OP_BR_C0) && !c_r) ||
                       ((opc == OP_BR_C1) && c_r) ||
                       ((opc == OP_BR_EQ) && z_r) ||
                       ((opc == OP_BR_H0) && !h_r);

   // Bit number and polarity sit in the opcode: even tests or sets a one
   assign bit_n   = opc[3:1];
   assign bit_val = mem_rdata[bit_n];
   assign bit_hit = (bit_val == !opc[0]);

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_mod
         assign mod_byte[gi] = (bit_n == gi) ? !opc[0] : mem_rdata[gi];
      end
   endgenerate

   // Arithmetic unit operands
   assign alu_bus.op  = !is_alu ? ((lo == LO_SHL) ? ALU_SHL : ALU_SHR) :
                        (lo == LO_ADC) ? ALU_ADC : (lo == LO_ADD) ? ALU_ADD : ALU_AND;
   assign alu_bus.a   = a_r;
   assign alu_bus.m   = !sh_inh ? mem_rdata : (hi == HI_SINA) ? a_r : x_r;
   assign alu_bus.cin = c_r;

   // Last data of the instruction is present this cycle
   assign exec_now = ((st_r == ST_FETCH) && (n_opr == 2'd0) && !need_rd) ||
                     ((st_r == ST_OPR1) && (n_opr == 2'd1) && !need_rd) ||
                     ((st_r == ST_OPR2) && (n_opr == 2'd2) && !need_rd) ||
                     (st_r == ST_READ);

   // Stop wakes only on the pin; wait also on an internal request
   assign wake = !irq_s2_r || (osc_r && int_req);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;   pc_nxt = pc_r;   addr_nxt = addr_r;  we_nxt = 1'b0;
      wdata_nxt = wdata_r;  op_nxt = op_r;  o1_nxt = o1_r;  o2_nxt = o2_r;
      a_nxt = a_r;  x_nxt = x_r;  sp_nxt = sp_r;
      h_nxt = h_r;  i_nxt = i_r;  n_nxt = n_r;  z_nxt = z_r;  c_nxt = c_r;
      osc_nxt = osc_r;  run_nxt = run_r;  done = 1'b0;
      case (st_r)
         ST_FETCH:
         begin
            op_nxt = mem_rdata;  pc_nxt = pc_inc;  addr_nxt = pc_inc;
            if (n_opr != 2'd0) st_nxt = ST_OPR1;
            else if (need_rd)
            begin
               st_nxt = ST_READ;
               addr_nxt = eff_addr;
            end
            else done = 1'b1;
         end
         ST_OPR1:
         begin
            o1_nxt = mem_rdata;  pc_nxt = pc_inc;  addr_nxt = pc_inc;
            if (n_opr == 2'd2) st_nxt = ST_OPR2;
            else if (need_rd)
            begin
               st_nxt = ST_READ;
               addr_nxt = eff_addr;
            end
            else done = 1'b1;
         end
         ST_OPR2:
         begin
            o2_nxt = mem_rdata;  pc_nxt = pc_inc;  addr_nxt = pc_inc;
            if (need_rd)
            begin
               st_nxt = ST_READ;
               addr_nxt = eff_addr;
            end
            else if (is_call)
            begin
               // Return address low byte first, high byte kept in o1
               st_nxt = ST_PUSH;  addr_nxt = {8'h00, sp_r};  we_nxt = 1'b1;
               wdata_nxt = pc_inc[7:0];  o1_nxt = pc_inc[15:8];
               sp_nxt = sp_r - 8'd1;  pc_nxt = jump_dest;
            end
            else done = 1'b1;
         end
         ST_READ:
         begin
            if (need_wr)
            begin
               st_nxt = ST_WRITE;  we_nxt = 1'b1;
               wdata_nxt = is_bitmod ? mod_byte : alu_bus.res;
            end
            else done = 1'b1;
         end
         ST_PUSH:
         begin
            st_nxt = ST_WRITE;  addr_nxt = {8'h00, sp_r};  we_nxt = 1'b1;
            wdata_nxt = o1_r;  sp_nxt = sp_r - 8'd1;
         end
         ST_HALT:
         begin
            if (wake)
            begin
               st_nxt = ST_FETCH;  osc_nxt = 1'b1;  run_nxt = 1'b1;
            end
         end
         default: done = 1'b1;                                              // Write and pad
      endcase

      // Execution effects at the cycle the last operand is present
      if (exec_now)
      begin
         if (is_alu)
         begin
            a_nxt = alu_bus.res;  n_nxt = alu_bus.n;  z_nxt = alu_bus.z;
            if (lo != LO_AND)
            begin
               h_nxt = alu_bus.h;  c_nxt = alu_bus.c;
            end
         end
         if (is_shift)
         begin
            n_nxt = alu_bus.n;  z_nxt = alu_bus.z;  c_nxt = alu_bus.c;
            if (hi == HI_SINA) a_nxt = alu_bus.res;
            if (hi == HI_SINX) x_nxt = alu_bus.res;
         end
         if (is_rel && br_cond) pc_nxt = pc_inc + off_ext;
         if (is_bitbr)
         begin
            c_nxt = bit_val;
            if (bit_hit) pc_nxt = pc_r + off_ext;
         end
         if (is_jump) pc_nxt = jump_dest;
         if (is_stop)
         begin
            i_nxt = 1'b0;  osc_nxt = 1'b0;  run_nxt = 1'b0;
         end
         if (is_wait)
         begin
            i_nxt = 1'b0;  run_nxt = 1'b0;
         end
      end

      // Finish: pad to the required count, then fetch or halt
      if (done)
      begin
         addr_nxt = pc_nxt;
         if (cyc_r < (cyc_need - 3'd1)) st_nxt = ST_PAD;
         else if (is_stop || is_wait) st_nxt = ST_HALT;
         else st_nxt = ST_FETCH;
      end
      cyc_nxt = (st_nxt == ST_FETCH) ? 3'd0 : (cyc_r + 3'd1);
   end

   // ----------------------------------------------------------------
   // Registers; the clock enable freezes everything
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r <= ST_FETCH;  pc_r <= PC_RESET;  addr_r <= PC_RESET;  we_r <= 1'b0;
         wdata_r <= 8'h00;  op_r <= 8'h00;  o1_r <= 8'h00;  o2_r <= 8'h00;
         a_r <= 8'h00;  x_r <= 8'h00;  sp_r <= SP_RESET;  cyc_r <= 3'd0;
         h_r <= 1'b0;  i_r <= 1'b1;  n_r <= 1'b0;  z_r <= 1'b0;  c_r <= 1'b0;
         osc_r <= 1'b1;  run_r <= 1'b1;  irq_s1_r <= 1'b1;  irq_s2_r <= 1'b1;
      end
      else if (core_ce)
      begin
         st_r <= st_nxt;  pc_r <= pc_nxt;  addr_r <= addr_nxt;  we_r <= we_nxt;
         wdata_r <= wdata_nxt;  op_r <= op_nxt;  o1_r <= o1_nxt;  o2_r <= o2_nxt;
         a_r <= a_nxt;  x_r <= x_nxt;  sp_r <= sp_nxt;  cyc_r <= cyc_nxt;
         h_r <= h_nxt;  i_r <= i_nxt;  n_r <= n_nxt;  z_r <= z_nxt;  c_r <= c_nxt;
         osc_r <= osc_nxt;  run_r <= run_nxt;
         irq_s1_r <= irq_pin_n;  irq_s2_r <= irq_s1_r;                      // Pin synchroniser
      end
   end

   assign mem_addr    = addr_r;
   assign mem_wdata   = wdata_r;
   assign mem_we      = we_r;
   assign osc_run     = osc_r;
   assign cpu_clk_run = run_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst || !core_ce);

   sequence s_rel_start;
      (st_r == ST_FETCH) && is_rel;
   endsequence
   sequence s_bitbr_start;
      (st_r == ST_FETCH) && is_bitbr;
   endsequence

   rel_not_taken_a: assert property ((st_r == ST_OPR1) && is_rel && !br_cond
      |=> pc_r == $past(pc_r) + 16'd1) else $error("untaken branch moved pc");
   rel_target_a: assert property ((st_r == ST_OPR1) && is_rel && br_cond
      |=> pc_r == $past(pc_r) + 16'd1 + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)})
      else $error("branch target wrong");
   rel_timing_a: assert property (s_rel_start
      |=> (st_r != ST_FETCH) [*2] ##1 (st_r == ST_FETCH)) else $error("branch not 3 cycles");
   rel_flags_a: assert property (s_rel_start
      |-> ##3 ({h_r, n_r, z_r, c_r} == $past({h_r, n_r, z_r, c_r}, 3)))
      else $error("branch changed flags");
   bitbr_len_a: assert property (s_bitbr_start
      |-> ##5 (st_r == ST_FETCH) && (pc_r == $past(pc_r, 5) + 16'd3 +
              ((c_r == !op_r[0]) ? {{8{o2_r[7]}}, o2_r} : 16'h0000)))
      else $error("bit branch length wrong");
   bit_carry_a: assert property ((st_r == ST_READ) && is_bitbr
      |=> c_r == $past(bit_val)) else $error("tested bit not in carry");
   bit_write_a: assert property ((st_r == ST_READ) && is_bitmod
      |=> mem_we && (mem_wdata[$past(bit_n)] == !$past(opc[0])))
      else $error("bit modify write wrong");
   and_flags_a: assert property (exec_now && is_alu && (lo == LO_AND)
      |=> $stable(c_r) && $stable(h_r)) else $error("and touched carry or half");
   shl_carry_a: assert property (exec_now && is_shift && (lo == LO_SHL)
      |=> c_r == $past(alu_bus.m[7])) else $error("shift left carry wrong");
   stop_osc_a: assert property (exec_now && is_stop
      |=> !osc_run && !cpu_clk_run && !i_r) else $error("stop did not halt");
   wait_clk_a: assert property (exec_now && is_wait
      |=> osc_run && !cpu_clk_run && !i_r) else $error("wait did not stop clock");

endmodule

// ==== verification/cbd_mem_model.sv ====
// Behavioural memory on the far side of the core's bus
`timescale 1ns/1ps
module cbd_mem_model
(
   input wire logic        core_clk,
   input wire logic [15:0] mem_addr,
   output logic [7:0]      mem_rdata,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_we
);
   logic [7:0] mem [0:65535];

   // Filler is an unlisted opcode, so stray fetches run as one-cycle idles
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h9D;
   end

   // Zero-latency read, as the core samples data in the address cycle
   assign mem_rdata = mem[mem_addr];

   // Plain always: the bench also loads code straight into the array
   always @(posedge core_clk)
   begin
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
   end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the branch, bit and control decode core
`timescale 1ns/1ps
module tb;
   logic        core_clk;
   logic        sys_rst;
   logic        core_ce;
   logic [15:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic [7:0]  mem_wdata;
   logic        mem_we;
   logic        irq_pin_n;
   logic        int_req;
   logic        osc_run;
   logic        cpu_clk_run;
   int          err_total;
   int          samples_checked;

   cbd_core dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .irq_pin_n(irq_pin_n), .int_req(int_req),
      .osc_run(osc_run), .cpu_clk_run(cpu_clk_run));
   cbd_mem_model mem_u (.core_clk(core_clk), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Reset lands the core on its first fetch at address zero
   task rst;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
   endtask

   // Loads three bytes at the fetch address, runs cyc clock cycles, checks next fetch
   task x(input logic [23:0] code, input int cyc, input logic [15:0] nxt);
      mem_u.mem[mem_addr] = code[23:16];
      mem_u.mem[mem_addr + 16'h0001] = code[15:8];
      mem_u.mem[mem_addr + 16'h0002] = code[7:0];
      repeat (cyc) @(posedge core_clk);
      #1;
      chk(mem_addr, nxt);
   endtask

   // Bounded wait, since wake-up latency depends on the pin synchroniser
   task seek(input logic [15:0] exp);
      for (int i = 0; i < 12 && mem_addr !== exp; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk(mem_addr, exp);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_branch;
      rst();
      x(24'h24_109D, 3, 16'h0012);
      x(24'h25_F09D, 3, 16'h0014);
      x(24'hAB_FF9D, 2, 16'h0016);
      x(24'hAB_019D, 2, 16'h0018);
      x(24'h27_049D, 3, 16'h001E);
      x(24'hA9_059D, 2, 16'h0020);
      x(24'h27_109D, 3, 16'h0022);
      x(24'h24_809D, 3, 16'hFFA4);
      x(24'h28_029D, 3, 16'hFFA8);
      $display("branch test done");
   endtask

   task t_bit;
      mem_u.mem[16'h0040] = 8'h82;
      rst();
      x(24'h10_409D, 5, 16'h0002);
      x(24'h13_409D, 5, 16'h0004);
      x(24'h01_40F0, 5, 16'h0007);
      x(24'h0E_4010, 5, 16'h001A);
      x(24'h24_109D, 3, 16'h001C);
      x(24'h05_40F0, 5, 16'h000F);
      x(24'h25_109D, 3, 16'h0011);
      chk({8'h00, mem_u.mem[16'h0040]}, 16'h0081);
      $display("bit test done");
   endtask

   task t_alu;
      mem_u.mem[16'h0050] = 8'h80;
      mem_u.mem[16'h0051] = 8'h81;
      rst();
      x(24'hAB_0F9D, 2, 16'h0002);
      x(24'hAB_019D, 2, 16'h0004);
      x(24'h28_109D, 3, 16'h0006);
      x(24'hA4_F09D, 2, 16'h0008);
      x(24'h28_109D, 3, 16'h000A);
      x(24'h38_509D, 5, 16'h000C);
      x(24'h37_519D, 5, 16'h000E);
      x(24'hA4_009D, 2, 16'h0010);
      x(24'h25_109D, 3, 16'h0022);
      x(24'h27_7F9D, 3, 16'h00A3);
      chk({mem_u.mem[16'h0050], mem_u.mem[16'h0051]}, 16'h00C0);
      $display("alu test done");
   endtask

   task t_ctrl;
      mem_u.mem[16'h1234] = 8'h92;
      mem_u.mem[16'h1237] = 8'h93;
      rst();
      x(24'h90_1234, 3, 16'h1234);
      repeat (6) @(posedge core_clk);
      #1;
      chk({14'h0000, osc_run, cpu_clk_run}, 16'h0000);
      @(posedge core_clk);
      int_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      chk({15'h0000, osc_run}, 16'h0000);
      @(posedge core_clk);
      int_req <= 1'b0;
      irq_pin_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      irq_pin_n <= 1'b1;
      seek(16'h1237);
      repeat (6) @(posedge core_clk);
      #1;
      chk({14'h0000, osc_run, cpu_clk_run}, 16'h0002);
      // Halted address already equals the next fetch, so watch the run flag
      @(posedge core_clk);
      int_req <= 1'b1;
      @(posedge core_clk);
      #1;
      chk({15'h0000, cpu_clk_run}, 16'h0001);
      @(posedge core_clk);
      #1;
      chk(mem_addr, 16'h1239);
      $display("control test done");
   endtask

   // Subroutine call pushes the return address, low byte first
   task t_call;
      rst();
      x(24'h91_0300, 5, 16'h0300);
      chk({mem_u.mem[16'h00FE], mem_u.mem[16'h00FF]}, 16'h0003);
      $display("call test done");
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #50000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   initial
   begin
      core_ce = 1'b1;
      sys_rst = 1'b1;
      irq_pin_n = 1'b1;
      int_req = 1'b0;
      err_total = 0;
      samples_checked = 0;
      t_branch();
      t_bit();
      t_alu();
      t_ctrl();
      t_call();
      test_done();
   end
endmodule
